// [src/dwt_pkg.sv]
// Package of constants for the DRAM write throttle block.
package dwt_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'he0;
    localparam logic [7:0] ERR_CMD_OFFSET = 8'h90;
    localparam logic [7:0] ERR_STS_OFFSET = 8'h91;
    localparam logic [63:0] CTRL_RESET = 64'h0;
    localparam logic [63:0] CTRL_WMASK = 64'h8000_3fff_ffff_fff8;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LOCK_BIT = 63;
    localparam int GWIN_LSB = 38;
    localparam int GTHR_LSB = 26;
    localparam int HOLD_LSB = 20;
    localparam int MWIN_LSB = 13;
    localparam int MLIM_LSB = 3;
    localparam int ERR_CMD_THR_BIT = 3;
    localparam int ERR_STS_WTHR_BIT = 11;
    localparam logic [7:0] ERR_CMD_RESET = 8'h80;
    localparam int GWIN_STEP_MS = 4;
    localparam int GTHR_SHIFT = 15;
    localparam int MWIN_PAD = 4;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
endpackage

// [src/dwt_window_timer.sv]
// Reusable window timer that pulses at the end of each window.
`timescale 1ns/1ns
module dwt_window_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [W-1:0] len_i,
    // Status
    output logic done_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // A zero length ends the window on every tick.
    always_comb begin
        cnt_nxt = cnt_r;
        done_o = 1'b0;
        if (restart_i) begin
            cnt_nxt = '0;
        end else if (tick_i) begin
            if (cnt_r + 1'b1 >= len_i) begin
                done_o = 1'b1;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// [src/dwt_top.sv]
// DRAM write throttle: configuration, windows, blocking and error flag.
`timescale 1ns/1ns
// What this block does
// - Global window length is field 45:38 times four milliseconds; zero gives one millisecond.
// - Count QWords per global window; engage throttling above threshold.
// - Global threshold is field 37:26 shifted left by fifteen.
// - Throttling lasts field 25:20 global windows once engaged; zero gives one window.
// - After the duration, stop limiting and resume global counting.
// - Monitor window is field 19:13 padded with four zeros, clocks.
// - While engaged, block writes once window count reaches maximum.
// - Per-window maximum is field 12:3, applied only when engaged.
// - Lock bit 63 resets low; once set the control register freezes.
// - Throttle event sets sticky status bit 11; write one clears.
// - Error command bit 3 enables the error report on throttle events.
module dwt_top #(
    parameter int MS_CYC = dwt_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Configuration access
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [63:0] cfg_wdata_i,
    input wire logic [7:0] cfg_be_i,
    output logic [63:0] cfg_rdata_o,
    // Write request path
    input wire logic qword_wr_i,
    output logic wr_block_o,
    // Status
    output logic throttle_active_o,
    output logic read_ctrl_locked_o,
    output logic serr_o
);
    typedef enum logic {DWT_IDLE, DWT_ENGAGED} dwt_state_t;

    dwt_state_t state_r, state_nxt;
    logic [63:0] ctrl_r, ctrl_nxt;
    logic [7:0] err_cmd_r, err_cmd_nxt;
    logic sts_r, sts_nxt;
    logic serr_r, serr_nxt;
    logic [63:0] rdata_r, rdata_nxt;
    logic [63:0] wmask;
    logic [31:0] gcnt_r, gcnt_nxt;
    logic [10:0] mcnt_r, mcnt_nxt;
    logic [5:0] hold_r, hold_nxt;
    logic blk_r, blk_nxt;
    logic ms_tick, g_done, m_done, event_hit, wr_take;
    logic [7:0] gwin;
    logic [11:0] gthr;
    logic [5:0] hold;
    logic [6:0] mwin;
    logic [9:0] mlim;
    logic [9:0] gwin_ms;
    logic [10:0] mwin_clk;
    logic [31:0] gthr_q;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    assign gwin = ctrl_r[dwt_pkg::GWIN_LSB +: 8];
    assign gthr = ctrl_r[dwt_pkg::GTHR_LSB +: 12];
    assign hold = ctrl_r[dwt_pkg::HOLD_LSB +: 6];
    assign mwin = ctrl_r[dwt_pkg::MWIN_LSB +: 7];
    assign mlim = ctrl_r[dwt_pkg::MLIM_LSB +: 10];
    assign gwin_ms = 10'(gwin * dwt_pkg::GWIN_STEP_MS);
    assign gthr_q = 32'(gthr) << dwt_pkg::GTHR_SHIFT;
    assign mwin_clk = 11'(mwin) << dwt_pkg::MWIN_PAD;

    // ------------------------------------------------------------------
    // Window timers
    // ------------------------------------------------------------------
    dwt_window_timer #(.W(32)) u_ms (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(1'b1),
        .restart_i(1'b0),
        .len_i(32'(MS_CYC)),
        .done_o(ms_tick)
    );

    dwt_window_timer #(.W(10)) u_gwin (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(ms_tick),
        .restart_i(1'b0),
        .len_i(gwin_ms),
        .done_o(g_done)
    );

    // The monitor window restarts whenever throttling is not engaged.
    dwt_window_timer #(.W(11)) u_mwin (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(1'b1),
        .restart_i(state_r != DWT_ENGAGED),
        .len_i(mwin_clk),
        .done_o(m_done)
    );

    // ------------------------------------------------------------------
    // Throttle state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        gcnt_nxt = gcnt_r;
        mcnt_nxt = mcnt_r;
        hold_nxt = hold_r;
        blk_nxt = blk_r;
        event_hit = 1'b0;
        // A blocked cycle is never counted, even if the path ignores the block.
        wr_take = qword_wr_i && !wr_block_o;
        if (wr_take) begin
            gcnt_nxt = gcnt_r + 32'h1;
            mcnt_nxt = mcnt_r + 11'h1;
        end
        case (state_r)
            DWT_IDLE: begin
                mcnt_nxt = '0;
                blk_nxt = 1'b0;
                if (g_done) begin
                    // A write in the closing cycle opens the next count.
                    gcnt_nxt = {31'h0, wr_take};
                    if (gcnt_r > gthr_q) begin
                        event_hit = 1'b1;
                        state_nxt = DWT_ENGAGED;
                        hold_nxt = hold;
                    end
                end
            end
            DWT_ENGAGED: begin
                if (m_done) begin
                    mcnt_nxt = {10'h0, wr_take};
                    blk_nxt = 1'b0;
                end
                if (mcnt_nxt >= {1'b0, mlim}) begin
                    blk_nxt = 1'b1;
                end
                if (g_done) begin
                    gcnt_nxt = {31'h0, wr_take};
                    if (hold_r <= 6'h1) begin
                        state_nxt = DWT_IDLE;
                        blk_nxt = 1'b0;
                        hold_nxt = '0;
                    end else begin
                        hold_nxt = hold_r - 6'h1;
                    end
                end
            end
            default: begin
                state_nxt = DWT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= DWT_IDLE;
            gcnt_r <= '0;
            mcnt_r <= '0;
            hold_r <= '0;
            blk_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gcnt_r <= gcnt_nxt;
            mcnt_r <= mcnt_nxt;
            hold_r <= hold_nxt;
            blk_r <= blk_nxt;
        end
    end

    // A zero maximum blocks at once while engaged.
    assign wr_block_o = (state_r == DWT_ENGAGED) &&
                        (blk_r || mlim == 10'h0);
    assign throttle_active_o = (state_r == DWT_ENGAGED);
    assign read_ctrl_locked_o = ctrl_r[dwt_pkg::LOCK_BIT];

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        err_cmd_nxt = err_cmd_r;
        sts_nxt = sts_r;
        rdata_nxt = '0;
        for (int i = 0; i < 8; i++) begin
            wmask[8*i +: 8] = {8{cfg_be_i[i]}};
        end
        wmask = wmask & dwt_pkg::CTRL_WMASK;
        if (cfg_wr_i && cfg_addr_i == dwt_pkg::CTRL_OFFSET &&
            !ctrl_r[dwt_pkg::LOCK_BIT]) begin
            ctrl_nxt = (ctrl_r & ~wmask) | (cfg_wdata_i & wmask);
        end else if (cfg_wr_i && cfg_addr_i == dwt_pkg::ERR_CMD_OFFSET &&
                     cfg_be_i[0]) begin
            err_cmd_nxt = cfg_wdata_i[7:0];
        end else if (cfg_wr_i && cfg_addr_i == dwt_pkg::ERR_STS_OFFSET &&
                     cfg_be_i[1] &&
                     cfg_wdata_i[dwt_pkg::ERR_STS_WTHR_BIT]) begin
            sts_nxt = 1'b0;
        end
        if (event_hit) begin
            sts_nxt = 1'b1;
        end
        if (cfg_addr_i == dwt_pkg::CTRL_OFFSET) begin
            rdata_nxt = ctrl_r;
        end else if (cfg_addr_i == dwt_pkg::ERR_CMD_OFFSET) begin
            rdata_nxt = {56'h0, err_cmd_r};
        end else if (cfg_addr_i == dwt_pkg::ERR_STS_OFFSET) begin
            rdata_nxt = {52'h0, sts_r, 11'h0};
        end
        serr_nxt = event_hit && err_cmd_r[dwt_pkg::ERR_CMD_THR_BIT];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= dwt_pkg::CTRL_RESET;
            err_cmd_r <= dwt_pkg::ERR_CMD_RESET;
            sts_r <= 1'b0;
            serr_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            err_cmd_r <= err_cmd_nxt;
            sts_r <= sts_nxt;
            serr_r <= serr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg_rdata_o = rdata_r;
    assign serr_o = serr_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    lock_freeze_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ctrl_r[dwt_pkg::LOCK_BIT] |=> $stable(ctrl_r))
        else $error("Locked control register changed");

    idle_noblock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == DWT_IDLE) |-> (!wr_block_o && !blk_r))
        else $error("Writes blocked while not engaged");

    engage_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == DWT_IDLE && g_done && gcnt_r > gthr_q)
        |=> (state_r == DWT_ENGAGED && sts_r))
        else $error("Threshold crossing did not engage");

    limit_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == DWT_ENGAGED && mcnt_r >= {1'b0, mlim} && !m_done
         && !g_done) |=> wr_block_o)
        else $error("Limit reached without blocking");

    serr_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        serr_o |-> $past(err_cmd_r[dwt_pkg::ERR_CMD_THR_BIT]))
        else $error("Error report without enable");

    sts_sticky_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (sts_r && !cfg_wr_i) |=> sts_r)
        else $error("Status flag lost without a clear");

    win_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        g_done |=> (gcnt_r <= 32'h1))
        else $error("Global counter not cleared");

    hold_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_r == DWT_ENGAGED && g_done && hold_r <= 6'h1)
        |=> state_r == DWT_IDLE)
        else $error("Throttling outlived its duration");
endmodule

// [verif/dwt_wr_source.sv]
// Behavioural model of the DRAM write request source.
`timescale 1ns/1ns
module dwt_wr_source (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic block_i,
    // Request path
    output logic qword_wr_o,
    output logic [31:0] accepted_o
);
    logic phase_r;
    // A blocked source holds back, so each pulse is a real transfer.
    assign qword_wr_o = en_i && !block_i && (!slow_i || phase_r);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_r <= 1'b0;
            accepted_o <= 32'h0;
        end else begin
            phase_r <= ~phase_r;
            if (qword_wr_o) begin
                accepted_o <= accepted_o + 32'h1;
            end
        end
    end
endmodule

// [verif/dram_write_throttle_test.sv]
// Self-checking testbench for the DRAM write throttle block.
`timescale 1ns/1ns
module dram_write_throttle_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cfg_wr_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00;
    logic [63:0] cfg_wdata_i = 64'h0;
    logic [7:0] cfg_be_i = 8'h00;
    logic [63:0] cfg_rdata_o, rd;
    logic qword_wr_i, wr_block_o, throttle_active_o, read_ctrl_locked_o;
    logic serr_o;
    logic src_en = 1'b0;
    logic src_slow = 1'b0;
    logic [31:0] src_acc;
    int fail_count = 0;
    int cmp_count = 0;
    int serr_seen = 0;
    always #2 clk_i = ~clk_i;
    always @(negedge clk_i) if (serr_o === 1'b1) serr_seen++;
    dwt_top #(.MS_CYC(4)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
        .cfg_rdata_o(cfg_rdata_o), .qword_wr_i(qword_wr_i),
        .wr_block_o(wr_block_o), .throttle_active_o(throttle_active_o),
        .read_ctrl_locked_o(read_ctrl_locked_o), .serr_o(serr_o));
    dwt_wr_source src_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .en_i(src_en), .slow_i(src_slow), .block_i(wr_block_o),
        .qword_wr_o(qword_wr_i), .accepted_o(src_acc));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [63:0] d,
                             input logic [7:0] be);
        @(posedge clk_i);
        #1;
        cfg_wr_i = 1'b1;
        cfg_addr_i = a;
        cfg_wdata_i = d;
        cfg_be_i = be;
        @(posedge clk_i);
        #1;
        cfg_wr_i = 1'b0;
    endtask
    task automatic cfg_read(input logic [7:0] a, output logic [63:0] d);
        @(posedge clk_i);
        #1;
        cfg_addr_i = a;
        @(posedge clk_i);
        #1;
        d = cfg_rdata_o;
    endtask
    // Waits for the engaged flag to reach a level; returns cycles spent.
    task automatic wait_act(input logic lvl, output int n);
        n = 0;
        while (throttle_active_o !== lvl && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 200) begin
            check({63'h0, throttle_active_o}, {63'h0, lvl});
            summarize();
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        cfg_read(dwt_pkg::CTRL_OFFSET, rd);
        check(rd, dwt_pkg::CTRL_RESET);
        cfg_read(dwt_pkg::ERR_CMD_OFFSET, rd);
        check(rd, {56'h0, dwt_pkg::ERR_CMD_RESET});
        cfg_read(dwt_pkg::ERR_STS_OFFSET, rd);
        check(rd, 64'h0);
        cfg_read(8'hf0, rd);
        check(rd, 64'h0);
    endtask
    task automatic t_fields();
        cfg_write(dwt_pkg::CTRL_OFFSET, 64'h7fff_ffff_ffff_ffff, 8'hff);
        cfg_read(dwt_pkg::CTRL_OFFSET, rd);
        check(rd, 64'h0000_3fff_ffff_fff8);
        cfg_write(dwt_pkg::CTRL_OFFSET, 64'hffff_ffff_ffff_ffff, 8'h01);
        cfg_read(dwt_pkg::CTRL_OFFSET, rd);
        check(rd, 64'h0000_3fff_ffff_fff8);
        check({63'h0, read_ctrl_locked_o}, 64'h0);
    endtask
    // Window 16 cycles, hold two windows, monitor 16 cycles, limit 2.
    task automatic t_throttle(input logic serr_en);
        int n;
        int dur;
        int s0;
        logic [31:0] acc0;
        cfg_write(dwt_pkg::ERR_CMD_OFFSET, {56'h0, 4'h8, serr_en, 3'h0},
                  8'h01);
        cfg_write(dwt_pkg::CTRL_OFFSET, (64'h1 << dwt_pkg::GWIN_LSB) |
                  (64'h2 << dwt_pkg::HOLD_LSB) |
                  (64'h1 << dwt_pkg::MWIN_LSB) |
                  (64'h2 << dwt_pkg::MLIM_LSB), 8'hff);
        s0 = serr_seen;
        src_slow = ~serr_en;
        src_en = 1'b1;
        wait_act(1'b1, n);
        acc0 = src_acc;
        wait_act(1'b0, dur);
        src_en = 1'b0;
        check({63'h0, dur >= 31 && dur <= 33}, 64'h1);
        n = src_acc - acc0;
        check({63'h0, n >= 2 && n <= 6}, 64'h1);
        repeat (40) @(posedge clk_i);
        #1;
        check({63'h0, throttle_active_o}, 64'h0);
        cfg_read(dwt_pkg::ERR_STS_OFFSET, rd);
        check(rd, 64'h800);
        check({63'h0, serr_seen > s0}, {63'h0, serr_en});
        cfg_write(dwt_pkg::ERR_STS_OFFSET, 64'h800, 8'h02);
        cfg_read(dwt_pkg::ERR_STS_OFFSET, rd);
        check(rd, 64'h0);
    endtask
    task automatic t_lock();
        cfg_write(dwt_pkg::CTRL_OFFSET, 64'h8000_0000_0000_0018, 8'hff);
        cfg_write(dwt_pkg::CTRL_OFFSET, 64'h0, 8'hff);
        cfg_read(dwt_pkg::CTRL_OFFSET, rd);
        check(rd, 64'h8000_0000_0000_0018);
        check({63'h0, read_ctrl_locked_o}, 64'h1);
    endtask
    // The limit must never bite while throttling is idle.
    always @(negedge clk_i) begin
        if (!sys_rst_i && throttle_active_o === 1'b0) begin
            check({63'h0, wr_block_o}, 64'h0);
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_fields();
        t_throttle(1'b1);
        t_throttle(1'b0);
        t_lock();
        summarize();
    end
endmodule
